/* File: optx_pkg.sv */
// shared constants and the pin synchroniser for the optical phy control block
`timescale 1ns/1ps
`default_nettype none
package optx_pkg;
   // control register 1.0 bit 11, held by this block
   localparam logic CTRL_LOW_POWER_RST = 1'b1;
   // status register 3.519 field positions, kept for software mapping
   localparam int STAT_TX_UP_BIT = 13;
   localparam int STAT_LOC_LOCK_BIT = 12;
   localparam int STAT_REM_LOCK_BIT = 11;
   localparam int STAT_REM_ACK_BIT = 10;
   // header lock hysteresis, in received blocks
   localparam logic [2:0] LOCK_GOOD_CNT = 3'h4;
   localparam logic [2:0] UNLOCK_BAD_CNT = 3'h2;
   // width of the synchronised pin bundle
   localparam int SYNC_W = 16;
   // bundle bit positions
   localparam int P_HDR_STROBE = 0;
   localparam int P_HDR_PRESENT = 1;
   localparam int P_LOCK_OK = 2;
   localparam int P_LINK_OK = 3;
   localparam int P_ZERO_BLOCK = 4;
   localparam int P_TRAIN_DONE = 5;
   localparam int P_GMII_EN = 6;
   localparam int P_GMII_ER = 7;
   localparam int P_GMII_D0 = 8;
   localparam logic [7:0] PAY_IDLE = 8'h00;
endpackage

module optx_sync
   import optx_pkg::*;
(
   input wire logic CLOCK, // system clock
   input wire logic RST_N, // synchronous reset, active low
   input wire logic [SYNC_W-1:0] d_async, // pins from outside the clock domain
   output logic [SYNC_W-1:0] q_sync // two-stage synchronised copy
);
   logic [SYNC_W-1:0] meta_reg;
   logic [SYNC_W-1:0] meta_next;
   logic [SYNC_W-1:0] sync_reg;
   logic [SYNC_W-1:0] sync_next;

   // first stage feeds only the second stage
   always_comb begin
      meta_next = d_async;
      sync_next = meta_reg;
   end

   // register both stages
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign q_sync = sync_reg;
endmodule
`default_nettype wire

/* File: optx_ctrl.sv */
// transmit and receive control of the optical phy: header lock, status bits, payload gating
`timescale 1ns/1ps
`default_nettype none
module optx_ctrl
   import optx_pkg::*;
(
   input wire logic CLOCK, // 100 MHz system clock
   input wire logic RST_N, // synchronous reset, active low
   input wire logic CTRL_WR_EN, // one-cycle write strobe for control bit 11
   input wire logic CTRL_WR_DATA, // value written to control bit 11
   input wire logic RX_HDR_STROBE, // level pulse, one received block decoded
   input wire logic RX_HDR_PRESENT, // block carried pilots and a header
   input wire logic RX_LOCK_OK, // peer_header_lock_field is OK
   input wire logic RX_LINK_OK, // peer_receive_link_field is OK
   input wire logic RX_ZERO_BLOCK, // block was all zero symbols
   input wire logic TRAIN_DONE, // level pulse, precoded link establishment complete
   input wire logic GMII_TX_EN, // host transmit enable
   input wire logic GMII_TX_ER, // host transmit error
   input wire logic [7:0] GMII_TXD, // host transmit octet
   output logic CTRL_LOW_POWER, // control bit 11 readback
   output logic STAT_LOC_LOCK, // status bit 12, local header lock
   output logic STAT_REM_LOCK, // status bit 11, remote header lock
   output logic STAT_REM_ACK, // status bit 10, partner acknowledged lock
   output logic STAT_TX_UP, // status bit 13, transmit control sending data
   output logic PAY_EN, // payload enable into the outgoing block
   output logic PAY_ER, // payload error into the outgoing block
   output logic [7:0] PAY_DATA // payload octet into the outgoing block
);
   typedef enum {TX_IDLE, TX_WAIT_TRAIN, TX_SEND_DATA} optx_tx_e;

   logic [SYNC_W-1:0] pins_async;
   logic [SYNC_W-1:0] pins_s;
   logic strobe_d_reg;
   logic strobe_d_next;
   logic train_d_reg;
   logic train_d_next;
   logic blk_ev;
   logic train_ev;
   logic hdr_present_s;
   logic lock_ok_s;
   logic link_ok_s;
   logic zero_s;
   logic gmii_en_s;
   logic gmii_er_s;
   logic [7:0] gmii_d_s;

   logic ctrl_reg;
   logic ctrl_next;
   logic [2:0] good_cnt_reg;
   logic [2:0] good_cnt_next;
   logic [2:0] bad_cnt_reg;
   logic [2:0] bad_cnt_next;
   logic loc_lock_reg;
   logic loc_lock_next;
   logic rem_lock_reg;
   logic rem_lock_next;
   logic rem_ack_reg;
   logic rem_ack_next;
   optx_tx_e state_reg;
   optx_tx_e state_next;
   logic tx_up_reg;
   logic tx_up_next;
   logic pay_en_reg;
   logic pay_en_next;
   logic pay_er_reg;
   logic pay_er_next;
   logic [7:0] pay_d_reg;
   logic [7:0] pay_d_next;

   // saturating block counter, used by both lock counters
   function automatic logic [2:0] sat_inc(input logic [2:0] v);
      sat_inc = (v == 3'h7) ? v : v + 3'h1;
   endfunction

   // every pin from the line side and the host side crosses two flip-flops
   assign pins_async = {GMII_TXD, GMII_TX_ER, GMII_TX_EN, TRAIN_DONE, RX_ZERO_BLOCK,
                        RX_LINK_OK, RX_LOCK_OK, RX_HDR_PRESENT, RX_HDR_STROBE};

   optx_sync u_sync (
      .CLOCK(CLOCK),
      .RST_N(RST_N),
      .d_async(pins_async),
      .q_sync(pins_s)
   );

   // unpack the synchronised bundle
   assign hdr_present_s = pins_s[P_HDR_PRESENT];
   assign lock_ok_s = pins_s[P_LOCK_OK];
   assign link_ok_s = pins_s[P_LINK_OK];
   assign zero_s = pins_s[P_ZERO_BLOCK];
   assign gmii_en_s = pins_s[P_GMII_EN];
   assign gmii_er_s = pins_s[P_GMII_ER];
   assign gmii_d_s = pins_s[P_GMII_D0 +: 8];

   // rising edges of the synchronised strobes; block fields must be stable around the strobe
   always_comb begin
      strobe_d_next = pins_s[P_HDR_STROBE];
      train_d_next = pins_s[P_TRAIN_DONE];
   end
   assign blk_ev = pins_s[P_HDR_STROBE] && !strobe_d_reg;
   assign train_ev = pins_s[P_TRAIN_DONE] && !train_d_reg;

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         strobe_d_reg <= 1'b0;
         train_d_reg <= 1'b0;
      end else begin
         strobe_d_reg <= strobe_d_next;
         train_d_reg <= train_d_next;
      end
   end

   // control bit 11 keeps whatever management last wrote
   always_comb begin
      ctrl_next = ctrl_reg;
      if (CTRL_WR_EN) begin
         ctrl_next = CTRL_WR_DATA;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         ctrl_reg <= CTRL_LOW_POWER_RST;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // receive control: hysteresis on header presence avoids lock chatter on one bad block
   always_comb begin
      good_cnt_next = good_cnt_reg;
      bad_cnt_next = bad_cnt_reg;
      loc_lock_next = loc_lock_reg;
      rem_lock_next = rem_lock_reg;
      rem_ack_next = rem_ack_reg;
      if (blk_ev) begin
         if (zero_s || !hdr_present_s) begin
            good_cnt_next = 3'h0;
            bad_cnt_next = sat_inc(bad_cnt_reg);
            if (sat_inc(bad_cnt_reg) >= UNLOCK_BAD_CNT) begin
               loc_lock_next = 1'b0;
            end
         end else begin
            bad_cnt_next = 3'h0;
            good_cnt_next = sat_inc(good_cnt_reg);
            if (sat_inc(good_cnt_reg) >= LOCK_GOOD_CNT) begin
               loc_lock_next = 1'b1;
            end
         end
         // peer status is only trusted from a block that carried a header
         if (hdr_present_s && !zero_s) begin
            rem_lock_next = lock_ok_s && loc_lock_next;
            if (lock_ok_s) begin
               rem_ack_next = 1'b1;
            end
         end
      end
      // without local lock remote lock clears with it; acknowledge clears one cycle after local lock drops
      if (!loc_lock_next) begin
         rem_lock_next = 1'b0;
         rem_ack_next = rem_ack_next && loc_lock_reg;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         good_cnt_reg <= 3'h0;
         bad_cnt_reg <= 3'h0;
         loc_lock_reg <= 1'b0;
         rem_lock_reg <= 1'b0;
         rem_ack_reg <= 1'b0;
      end else begin
         good_cnt_reg <= good_cnt_next;
         bad_cnt_reg <= bad_cnt_next;
         loc_lock_reg <= loc_lock_next;
         rem_lock_reg <= rem_lock_next;
         rem_ack_reg <= rem_ack_next;
      end
   end

   // transmit control; low power or lost lock forces a full retrain
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         TX_IDLE: begin
            if (!ctrl_reg && loc_lock_reg) begin
               state_next = TX_WAIT_TRAIN;
            end
         end
         TX_WAIT_TRAIN: begin
            if (ctrl_reg || !loc_lock_reg) begin
               state_next = TX_IDLE;
            end else if (train_ev) begin
               state_next = TX_SEND_DATA;
            end
         end
         TX_SEND_DATA: begin
            if (ctrl_reg || !loc_lock_reg) begin
               state_next = TX_IDLE;
            end else if (blk_ev && hdr_present_s && !zero_s && !link_ok_s) begin
               state_next = TX_WAIT_TRAIN;
            end
         end
         default: begin
            state_next = TX_IDLE;
         end
      endcase
      tx_up_next = (state_next == TX_SEND_DATA);
   end

   // payload mux: host frames only while sending data, idle octets otherwise
   always_comb begin
      pay_en_next = 1'b0;
      pay_er_next = 1'b0;
      pay_d_next = PAY_IDLE;
      if (tx_up_reg) begin
         pay_en_next = gmii_en_s;
         pay_er_next = gmii_er_s;
         pay_d_next = gmii_d_s;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         state_reg <= TX_IDLE;
         tx_up_reg <= 1'b0;
         pay_en_reg <= 1'b0;
         pay_er_reg <= 1'b0;
         pay_d_reg <= PAY_IDLE;
      end else begin
         state_reg <= state_next;
         tx_up_reg <= tx_up_next;
         pay_en_reg <= pay_en_next;
         pay_er_reg <= pay_er_next;
         pay_d_reg <= pay_d_next;
      end
   end

   // status bits are straight flop copies, so reads track state without a write path
   assign CTRL_LOW_POWER = ctrl_reg;
   assign STAT_LOC_LOCK = loc_lock_reg;
   assign STAT_REM_LOCK = rem_lock_reg;
   assign STAT_REM_ACK = rem_ack_reg;
   assign STAT_TX_UP = tx_up_reg;
   assign PAY_EN = pay_en_reg;
   assign PAY_ER = pay_er_reg;
   assign PAY_DATA = pay_d_reg;

   // a written control value shows on the next cycle
   chk_ctrl_write: assert property (@(posedge CLOCK) disable iff (!RST_N)
      CTRL_WR_EN |=> CTRL_LOW_POWER == $past(CTRL_WR_DATA))
      else $error("control bit did not take written value");

   // control bit holds between writes
   chk_ctrl_hold: assert property (@(posedge CLOCK) disable iff (!RST_N)
      !CTRL_WR_EN |=> $stable(CTRL_LOW_POWER))
      else $error("control bit changed without a write");

   // enough good blocks give lock
   chk_lock_acquire: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (blk_ev && hdr_present_s && !zero_s && good_cnt_reg == LOCK_GOOD_CNT - 3'h1) |=> STAT_LOC_LOCK)
      else $error("local lock not set after good blocks");

   // enough zero blocks drop lock
   chk_lock_drop: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (blk_ev && zero_s && bad_cnt_reg == UNLOCK_BAD_CNT - 3'h1) |=> !STAT_LOC_LOCK)
      else $error("local lock not dropped after zero blocks");

   // remote lock never set by a NOT_OK header
   chk_rem_notok: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (blk_ev && hdr_present_s && !zero_s && !lock_ok_s) |=> !STAT_REM_LOCK)
      else $error("remote lock set on NOT_OK header");

   // OK header under lock sets acknowledge
   chk_rem_ack: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (blk_ev && hdr_present_s && !zero_s && lock_ok_s && loc_lock_reg) |=> STAT_REM_ACK)
      else $error("acknowledge not set on OK header");

   // training completion brings link up
   chk_link_up: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (state_reg == TX_WAIT_TRAIN && train_ev && !ctrl_reg && loc_lock_reg) |=> STAT_TX_UP)
      else $error("link up not set after training");

   // peer NOT_OK link status drops link up
   chk_link_down: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (STAT_TX_UP && blk_ev && hdr_present_s && !zero_s && !link_ok_s) |=> !STAT_TX_UP)
      else $error("link up kept after peer NOT_OK");

   // frames pass unaltered while up
   chk_pay_pass: assert property (@(posedge CLOCK) disable iff (!RST_N)
      STAT_TX_UP |=> (PAY_EN == $past(gmii_en_s) && PAY_ER == $past(gmii_er_s) && PAY_DATA == $past(gmii_d_s)))
      else $error("payload differs from host frame");

   // no host frames while down
   chk_pay_block: assert property (@(posedge CLOCK) disable iff (!RST_N)
      !STAT_TX_UP |=> (!PAY_EN && !PAY_ER && PAY_DATA == PAY_IDLE))
      else $error("host frame leaked while link down");

   // status follows the state machine
   chk_status_follow: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (STAT_TX_UP == (state_reg == TX_SEND_DATA)) && (STAT_LOC_LOCK || !STAT_REM_LOCK))
      else $error("status bits disagree with state");
endmodule
`default_nettype wire

/* File: optx_peer.sv */
// far-end model: remote phy that sends decoded block headers and link training events
`timescale 1ns/1ps
`default_nettype none
module optx_peer (
   input wire logic CLOCK, // system clock
   output logic RX_HDR_STROBE, // one pulse per block
   output logic RX_HDR_PRESENT, // pilots and header present
   output logic RX_LOCK_OK, // peer_header_lock_field
   output logic RX_LINK_OK, // peer_receive_link_field
   output logic RX_ZERO_BLOCK, // all zero symbols
   output logic TRAIN_DONE // link establishment finished
);
   // idle at time zero: no block, no training
   initial begin
      RX_HDR_STROBE = 1'b0;
      RX_HDR_PRESENT = 1'b0;
      RX_LOCK_OK = 1'b0;
      RX_LINK_OK = 1'b0;
      RX_ZERO_BLOCK = 1'b0;
      TRAIN_DONE = 1'b0;
   end
   // one block: fields held across the strobe, 3 high and 3 low keeps the sync spacing
   task automatic send_block(input logic p, input logic z, input logic lk, input logic ln);
      @(posedge CLOCK);
      RX_HDR_PRESENT <= p;
      RX_ZERO_BLOCK <= z;
      RX_LOCK_OK <= lk;
      RX_LINK_OK <= ln;
      RX_HDR_STROBE <= 1'b1;
      repeat (3) @(posedge CLOCK);
      RX_HDR_STROBE <= 1'b0;
      repeat (3) @(posedge CLOCK);
   endtask
   // training completion pulse, long enough for the two-stage synchroniser
   task automatic train();
      @(posedge CLOCK);
      TRAIN_DONE <= 1'b1;
      repeat (3) @(posedge CLOCK);
      TRAIN_DONE <= 1'b0;
      repeat (3) @(posedge CLOCK);
   endtask
endmodule
`default_nettype wire

/* File: optx_tb.sv */
// self-checking bench for the optical phy transmit and receive control
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import optx_pkg::*;
   logic CLOCK = 1'b0;
   logic RST_N = 1'b0;
   logic CTRL_WR_EN = 1'b0;
   logic CTRL_WR_DATA = 1'b0;
   logic GMII_TX_EN = 1'b0;
   logic GMII_TX_ER = 1'b0;
   logic [7:0] GMII_TXD = 8'h00;
   logic rx_stb, rx_pres, rx_lok, rx_lnk, rx_zero, trn;
   logic low_pwr, loc_lock, rem_lock, rem_ack, tx_up, pay_en, pay_er;
   logic [7:0] pay_data;
   logic [9:0] hist [3];
   logic pay_chk = 1'b0;
   logic up_d = 1'b0;
   int bad_count = 0;
   int tests_run = 0;
   int cycles = 0;
   always #5 CLOCK = ~CLOCK;
   optx_peer peer (.CLOCK(CLOCK), .RX_HDR_STROBE(rx_stb), .RX_HDR_PRESENT(rx_pres), .RX_LOCK_OK(rx_lok),
      .RX_LINK_OK(rx_lnk), .RX_ZERO_BLOCK(rx_zero), .TRAIN_DONE(trn));
   optx_ctrl DUT (.CLOCK(CLOCK), .RST_N(RST_N), .CTRL_WR_EN(CTRL_WR_EN), .CTRL_WR_DATA(CTRL_WR_DATA),
      .RX_HDR_STROBE(rx_stb), .RX_HDR_PRESENT(rx_pres), .RX_LOCK_OK(rx_lok), .RX_LINK_OK(rx_lnk),
      .RX_ZERO_BLOCK(rx_zero), .TRAIN_DONE(trn), .GMII_TX_EN(GMII_TX_EN), .GMII_TX_ER(GMII_TX_ER),
      .GMII_TXD(GMII_TXD), .CTRL_LOW_POWER(low_pwr), .STAT_LOC_LOCK(loc_lock), .STAT_REM_LOCK(rem_lock),
      .STAT_REM_ACK(rem_ack), .STAT_TX_UP(tx_up), .PAY_EN(pay_en), .PAY_ER(pay_er), .PAY_DATA(pay_data));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // the four status bits as one nibble: tx_up, loc, rem, ack
   task automatic check_stat(input string what, input logic [3:0] exp);
      repeat (2) @(posedge CLOCK);
      #1;
      check(what, {12'h000, tx_up, loc_lock, rem_lock, rem_ack}, {12'h000, exp});
   endtask
   task automatic write_ctrl(input logic d);
      @(posedge CLOCK);
      CTRL_WR_EN <= 1'b1;
      CTRL_WR_DATA <= d;
      @(posedge CLOCK);
      CTRL_WR_EN <= 1'b0;
      #1;
      check("ctrl bit 11", {15'h0000, low_pwr}, {15'h0000, d});
   endtask
   // crc over the 64 test octets, sent low octet first
   function automatic logic [31:0] frame_crc();
      logic [31:0] c;
      c = 32'hffffffff;
      for (int i = 0; i < 64; i++) begin
         c ^= {24'h000000, (i % 2 == 1) ? 8'ha5 : 8'h5a};
         for (int j = 0; j < 8; j++) begin
            c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
         end
      end
      return ~c;
   endfunction
   // host frame: preamble, delimiter, 64 octets, crc, 12 idles
   task automatic send_frame();
      logic [31:0] crc;
      crc = frame_crc();
      pay_chk = 1'b1;
      for (int i = 0; i < 88; i++) begin
         @(posedge CLOCK);
         GMII_TX_EN <= (i < 76);
         GMII_TX_ER <= 1'b0;
         if (i < 7) GMII_TXD <= 8'h55;
         else if (i == 7) GMII_TXD <= 8'hd5;
         else if (i < 72) GMII_TXD <= (i % 2 == 1) ? 8'ha5 : 8'h5a;
         else if (i < 76) GMII_TXD <= crc[8*(i-72) +: 8];
         else GMII_TXD <= 8'h00;
      end
      repeat (4) @(posedge CLOCK);
      pay_chk = 1'b0;
   endtask
   // drive history: what was put on the host pins three edges ago
   always @(posedge CLOCK) begin
      hist[0] <= {GMII_TX_EN, GMII_TX_ER, GMII_TXD};
      hist[1] <= hist[0];
      hist[2] <= hist[1];
   end
   // payload follows host pins only while link up is steady, else stays idle
   always @(negedge CLOCK) begin
      if (pay_chk && up_d === tx_up) begin
         check("payload", {6'h00, pay_en, pay_er, pay_data}, tx_up ? {6'h00, hist[2]} : 16'h0000);
      end
      up_d <= tx_up;
   end
   // hang guard, generous against the roughly 450 cycles the run needs
   always @(posedge CLOCK) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test();
      end
   end
   initial begin
      repeat (6) @(posedge CLOCK);
      RST_N <= 1'b1;
      #1;
      check("reset", {10'h000, low_pwr, tx_up, loc_lock, rem_lock, rem_ack, pay_en}, 16'h0020);
      repeat (10) @(posedge CLOCK);
      write_ctrl(1'b0);
      for (int n = 0; n < 4; n++) begin
         peer.send_block(1'b1, 1'b0, 1'b0, 1'b0);
         check_stat("lock count", (n == 3) ? 4'h4 : 4'h0);
      end
      peer.send_block(1'b0, 1'b1, 1'b0, 1'b0);
      check_stat("one zero block", 4'h4);
      peer.send_block(1'b0, 1'b1, 1'b0, 1'b0);
      check_stat("lock drop", 4'h0);
      repeat (4) peer.send_block(1'b1, 1'b0, 1'b0, 1'b0);
      check_stat("relock", 4'h4);
      peer.send_block(1'b1, 1'b0, 1'b1, 1'b0);
      check_stat("peer ack", 4'h7);
      // training only once local lock reads set
      if (loc_lock === 1'b1) peer.train();
      check_stat("link up", 4'hf);
      send_frame();
      peer.send_block(1'b1, 1'b0, 1'b1, 1'b1);
      check_stat("link ok held", 4'hf);
      peer.send_block(1'b1, 1'b0, 1'b1, 1'b1);
      check_stat("link ok kept", 4'hf);
      peer.send_block(1'b1, 1'b0, 1'b1, 1'b0);
      check_stat("link down", 4'h7);
      // second read well inside one block time
      check_stat("link down reread", 4'h7);
      send_frame();
      peer.train();
      check_stat("retrain", 4'hf);
      send_frame();
      // low power forces the transmit side back to idle
      write_ctrl(1'b1);
      check_stat("low power", 4'h7);
      // a NOT_OK header clears remote lock even under local lock
      peer.send_block(1'b1, 1'b0, 1'b0, 1'b1);
      check_stat("remote not ok", 4'h5);
      end_of_test();
   end
endmodule
`default_nettype wire
